// >>> rps_cfg.svh
// Constants for the remappable pin select crossbar.
// Assumes inclusion by bare name from files in the same folder.
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// ----------------------------------------
// Field geometry and counts
// ----------------------------------------
`define RPS_SEL_W        6
`define RPS_PHYS_PINS    30
`define RPS_VIRT_PINS    4
`define RPS_VIRT_BASE    6'h20
`define RPS_IN_FUNCS     23
`define RPS_OUT_FUNCS    16

// ----------------------------------------
// Reset values and special codes
// ----------------------------------------
`define RPS_IN_RESET     6'h3f
`define RPS_IN_GROUND    6'h3f
`define RPS_OUT_NULL     6'h00

// ----------------------------------------
// Output function codes
// ----------------------------------------
`define RPS_OC_UTX       6'h03
`define RPS_OC_URTS      6'h04
`define RPS_OC_SDO       6'h07
`define RPS_OC_SCKO      6'h08
`define RPS_OC_SSO       6'h09
`define RPS_OC_CMP1      6'h12
`define RPS_OC_CMP2      6'h13
`define RPS_OC_SYNC      6'h25
`define RPS_OC_REFCLK    6'h26
`define RPS_OC_ANA1      6'h27
`define RPS_OC_ANA2      6'h28
`define RPS_OC_ANA3      6'h29
`define RPS_OC_ANA4      6'h2a
`define RPS_OC_PWMHI     6'h2c
`define RPS_OC_PWMLO     6'h2d

`endif

// >>> rps_pkg.sv
// Types for the remappable pin select crossbar.
// Assumes rps_cfg.svh sits in the same folder.
`include "rps_cfg.svh"
package rps_pkg;
   typedef logic [`RPS_SEL_W-1:0] rps_sel_type;
endpackage

// >>> rps_in_mux.sv
// One peripheral input selector: pin number to input level.
// Assumes the pin vector already holds physical then virtual pins.
`timescale 1ns/1ns
`include "rps_cfg.svh"
module rps_in_mux #(
   parameter int NPINS = `RPS_PHYS_PINS + `RPS_VIRT_PINS
) (
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic [63:0]        pin_vec,
   input  wire rps_pkg::rps_sel_type sel,
   output logic                    in_out
);
   logic in_reg;
   logic in_next;

   // ----------------------------------------
   // Selection
   // ----------------------------------------
   // Physical pins sit below their count, virtual pins from their base up;
   // the gap between and codes past the last virtual pin read ground
   always_comb begin
      in_next = 1'b0;
      if (sel != `RPS_IN_GROUND) begin
         if (32'(sel) < NPINS - `RPS_VIRT_PINS) begin
            in_next = pin_vec[sel];
         end else if (sel >= `RPS_VIRT_BASE &&
                      32'(sel - `RPS_VIRT_BASE) < `RPS_VIRT_PINS) begin
            in_next = pin_vec[sel];
         end
      end
   end

   // Registered so the top's inputs come straight off flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_reg <= 1'b0;
      end else begin
         in_reg <= in_next;
      end
   end

   assign in_out = in_reg;

   ground_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel == `RPS_IN_GROUND |=> !in_out) else $error("ground select not low");
endmodule // rps_in_mux

// >>> rps_out_mux.sv
// One pin's output selector: function code to data and enable.
// Assumes peripheral outputs arrive as a code-indexed table.
`timescale 1ns/1ns
`include "rps_cfg.svh"
module rps_out_mux (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire rps_pkg::rps_sel_type sel,
   input  wire logic [63:0]          fn_data,
   input  wire logic [63:0]          fn_oe,
   input  wire logic                 port_data,
   input  wire logic                 port_oe,
   output logic                      pin_data,
   output logic                      pin_oe
);
   logic data_reg;
   logic data_next;
   logic oe_reg;
   logic oe_next;

   // ----------------------------------------
   // Selection
   // ----------------------------------------
   // Null code and unused codes leave the port logic in charge
   always_comb begin
      data_next = port_data;
      oe_next   = port_oe;
      if (sel != `RPS_OUT_NULL && fn_oe[sel]) begin
         data_next = fn_data[sel];
         oe_next   = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= 1'b0;
         oe_reg   <= 1'b0;
      end else begin
         data_reg <= data_next;
         oe_reg   <= oe_next;
      end
   end

   assign pin_data = data_reg;
   assign pin_oe   = oe_reg;

   null_passes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel == `RPS_OUT_NULL |=> pin_data == $past(port_data) && pin_oe == $past(port_oe))
      else $error("null code did not pass port");
endmodule // rps_out_mux

// >>> rps_top.sv
// Remappable pin select crossbar: input and output routing.
// Assumes synchronous peripheral and port signals on sys_clk.
`timescale 1ns/1ns
`include "rps_cfg.svh"
module rps_top #(
   parameter int NPINS = `RPS_PHYS_PINS
) (
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   // Configuration
   input  wire logic                         remap_write_lock,
   input  wire logic                         in_sel_we,
   input  wire logic [4:0]                   in_sel_idx,
   input  wire logic                         out_sel_we,
   input  wire logic [5:0]                   out_sel_idx,
   input  wire rps_pkg::rps_sel_type         sel_wdata,
   output logic [`RPS_IN_FUNCS*6-1:0]        input_select_register,
   output logic [(NPINS+4)*6-1:0]            output_select_register,
   // Pads and port logic
   input  wire logic [NPINS-1:0]             pad_in,
   input  wire logic [NPINS-1:0]             port_data,
   input  wire logic [NPINS-1:0]             port_oe,
   output logic [NPINS-1:0]                  pad_out,
   output logic [NPINS-1:0]                  pad_oe,
   // Peripheral outputs
   input  wire logic                         serial_transmit_out,
   input  wire logic                         serial_request_send_out,
   input  wire logic                         spi_data_out,
   input  wire logic                         spi_clock_out,
   input  wire logic                         spi_clock_oe,
   input  wire logic                         spi_select_out,
   input  wire logic                         spi_select_oe,
   input  wire logic                         compare_out_first,
   input  wire logic                         compare_out_second,
   input  wire logic                         pwm_sync_out,
   input  wire logic                         reference_clock_out,
   input  wire logic [3:0]                   comparator_out,
   input  wire logic                         pwm_gen_four_high,
   input  wire logic                         pwm_gen_four_low,
   // Peripheral inputs, order of the input function list
   output logic [`RPS_IN_FUNCS-1:0]          periph_in
);
   localparam int NALL = NPINS + `RPS_VIRT_PINS;

   rps_pkg::rps_sel_type in_sel_reg  [`RPS_IN_FUNCS];
   rps_pkg::rps_sel_type in_sel_next [`RPS_IN_FUNCS];
   rps_pkg::rps_sel_type out_sel_reg [NALL];
   rps_pkg::rps_sel_type out_sel_next[NALL];
   logic [63:0]          fn_data;
   logic [63:0]          fn_oe;
   logic [63:0]          pin_vec;
   logic [NALL-1:0]      all_data;
   logic [NALL-1:0]      all_oe;
   logic [NALL-1:0]      port_d_all;
   logic [NALL-1:0]      port_oe_all;

   // ----------------------------------------
   // Selection registers
   // ----------------------------------------
   // Writes simply vanish while locked, as software expects
   always_comb begin
      for (int i = 0; i < `RPS_IN_FUNCS; i++) begin
         in_sel_next[i] = in_sel_reg[i];
      end
      for (int j = 0; j < NALL; j++) begin
         out_sel_next[j] = out_sel_reg[j];
      end
      if (!remap_write_lock && in_sel_we && 32'(in_sel_idx) < `RPS_IN_FUNCS) begin
         in_sel_next[in_sel_idx] = sel_wdata;
      end
      if (!remap_write_lock && out_sel_we && 32'(out_sel_idx) < NALL) begin
         out_sel_next[out_sel_idx] = sel_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `RPS_IN_FUNCS; i++) begin
            in_sel_reg[i] <= `RPS_IN_RESET;
         end
         for (int j = 0; j < NALL; j++) begin
            out_sel_reg[j] <= `RPS_OUT_NULL;
         end
      end else begin
         in_sel_reg  <= in_sel_next;
         out_sel_reg <= out_sel_next;
      end
   end

   // ----------------------------------------
   // Readback (flops directly)
   // ----------------------------------------
   for (genvar g = 0; g < `RPS_IN_FUNCS; g++) begin : g_in_rb
      assign input_select_register[g*`RPS_SEL_W +: `RPS_SEL_W] = in_sel_reg[g];
   end
   for (genvar g = 0; g < NALL; g++) begin : g_out_rb
      assign output_select_register[g*`RPS_SEL_W +: `RPS_SEL_W] = out_sel_reg[g];
   end

   // ----------------------------------------
   // Output function table, indexed by code
   // ----------------------------------------
   // SPI clock and select are two-way; others always drive
   always_comb begin
      fn_data = 64'h0;
      fn_oe   = 64'h0;
      fn_data[`RPS_OC_UTX]    = serial_transmit_out;
      fn_oe[`RPS_OC_UTX]      = 1'b1;
      fn_data[`RPS_OC_URTS]   = serial_request_send_out;
      fn_oe[`RPS_OC_URTS]     = 1'b1;
      fn_data[`RPS_OC_SDO]    = spi_data_out;
      fn_oe[`RPS_OC_SDO]      = 1'b1;
      fn_data[`RPS_OC_SCKO]   = spi_clock_out;
      fn_oe[`RPS_OC_SCKO]     = spi_clock_oe;
      fn_data[`RPS_OC_SSO]    = spi_select_out;
      fn_oe[`RPS_OC_SSO]      = spi_select_oe;
      fn_data[`RPS_OC_CMP1]   = compare_out_first;
      fn_oe[`RPS_OC_CMP1]     = 1'b1;
      fn_data[`RPS_OC_CMP2]   = compare_out_second;
      fn_oe[`RPS_OC_CMP2]     = 1'b1;
      fn_data[`RPS_OC_SYNC]   = pwm_sync_out;
      fn_oe[`RPS_OC_SYNC]     = 1'b1;
      fn_data[`RPS_OC_REFCLK] = reference_clock_out;
      fn_oe[`RPS_OC_REFCLK]   = 1'b1;
      fn_data[`RPS_OC_ANA1]   = comparator_out[0];
      fn_data[`RPS_OC_ANA2]   = comparator_out[1];
      fn_data[`RPS_OC_ANA3]   = comparator_out[2];
      fn_data[`RPS_OC_ANA4]   = comparator_out[3];
      fn_oe[`RPS_OC_ANA1]     = 1'b1;
      fn_oe[`RPS_OC_ANA2]     = 1'b1;
      fn_oe[`RPS_OC_ANA3]     = 1'b1;
      fn_oe[`RPS_OC_ANA4]     = 1'b1;
      fn_data[`RPS_OC_PWMHI]  = pwm_gen_four_high;
      fn_oe[`RPS_OC_PWMHI]    = 1'b1;
      fn_data[`RPS_OC_PWMLO]  = pwm_gen_four_low;
      fn_oe[`RPS_OC_PWMLO]    = 1'b1;
   end

   // ----------------------------------------
   // Per-pin output muxes, physical then virtual
   // ----------------------------------------
   // Virtual pins have no port logic behind them
   assign port_d_all  = {{`RPS_VIRT_PINS{1'b0}}, port_data};
   assign port_oe_all = {{`RPS_VIRT_PINS{1'b0}}, port_oe};

   for (genvar p = 0; p < NALL; p++) begin : g_out
      rps_out_mux u_out (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .sel       (out_sel_reg[p]),
         .fn_data   (fn_data),
         .fn_oe     (fn_oe),
         .port_data (port_d_all[p]),
         .port_oe   (port_oe_all[p]),
         .pin_data  (all_data[p]),
         .pin_oe    (all_oe[p])
      );
   end

   assign pad_out = all_data[NPINS-1:0];
   assign pad_oe  = all_oe[NPINS-1:0];

   // ----------------------------------------
   // Input side: pins read as the pad sees them
   // ----------------------------------------
   // Pad level is read regardless of direction; setting the
   // direction to input is software's job
   always_comb begin
      pin_vec = 64'h0;
      pin_vec[NPINS-1:0] = pad_in;
      for (int v = 0; v < `RPS_VIRT_PINS; v++) begin
         pin_vec[`RPS_VIRT_BASE + v] = all_data[NPINS + v];
      end
   end

   // One selector per peripheral input, independent of outputs
   for (genvar f = 0; f < `RPS_IN_FUNCS; f++) begin : g_in
      rps_in_mux #(
         .NPINS (NALL)
      ) u_in (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .pin_vec (pin_vec),
         .sel     (in_sel_reg[f]),
         .in_out  (periph_in[f])
      );
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Writes land one cycle on, and vanish while the lock is set
   lock_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      remap_write_lock && in_sel_we |=> $stable(input_select_register))
      else $error("locked write changed input select");

   out_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      remap_write_lock && out_sel_we |=> $stable(output_select_register))
      else $error("locked write changed output select");

   unlock_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !remap_write_lock && out_sel_we && out_sel_idx == 6'h00 |=>
      output_select_register[5:0] == $past(sel_wdata))
      else $error("unlocked write lost");

   in_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !remap_write_lock && in_sel_we && in_sel_idx == 5'h00 |=>
      input_select_register[5:0] == $past(sel_wdata))
      else $error("unlocked input write lost");

   // ----------------------------------------
   // Routes seen on pin zero and the first virtual pin
   // ----------------------------------------
   // Every pin is the same generate copy, so one pin stands for all
   sequence uart_sel_s;
      output_select_register[5:0] == `RPS_OC_UTX;
   endsequence
   uart_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      uart_sel_s |=> pad_out[0] == $past(serial_transmit_out) && pad_oe[0])
      else $error("transmit not on pin");

   rts_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_URTS |=>
      pad_out[0] == $past(serial_request_send_out) && pad_oe[0])
      else $error("request-send not on pin");

   null_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OUT_NULL |=>
      pad_out[0] == $past(port_data[0]) && pad_oe[0] == $past(port_oe[0]))
      else $error("null code did not leave port in charge");

   // Always-driving functions: data follows the source; enable high checked for all but ANA3 and PWMLO
   sdo_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_SDO |=>
      pad_out[0] == $past(spi_data_out) && pad_oe[0])
      else $error("spi data not on pin");

   cmp_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_CMP1 |=>
      pad_out[0] == $past(compare_out_first) && pad_oe[0])
      else $error("compare one not on pin");

   cmp_second_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_CMP2 |=>
      pad_out[0] == $past(compare_out_second) && pad_oe[0])
      else $error("compare two not on pin");

   sync_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_SYNC |=>
      pad_out[0] == $past(pwm_sync_out) && pad_oe[0])
      else $error("sync out not on pin");

   refclk_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_REFCLK |=>
      pad_out[0] == $past(reference_clock_out) && pad_oe[0])
      else $error("reference clock not on pin");

   comp_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_ANA1 |=>
      pad_out[0] == $past(comparator_out[0]) && pad_oe[0])
      else $error("comparator one not on pin");

   comp_second_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_ANA2 |=>
      pad_out[0] == $past(comparator_out[1]) && pad_oe[0])
      else $error("comparator two not on pin");

   comp_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_ANA3 |=> pad_out[0] == $past(comparator_out[2]))
      else $error("comparator three not on pin");

   comp_fourth_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_ANA4 |=>
      pad_out[0] == $past(comparator_out[3]) && pad_oe[0])
      else $error("comparator four not on pin");

   pwm_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_PWMHI |=>
      pad_out[0] == $past(pwm_gen_four_high) && pad_oe[0])
      else $error("pwm high not on pin");

   pwm_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_PWMLO |=> pad_out[0] == $past(pwm_gen_four_low))
      else $error("pwm low not on pin");

   // Looped pin: two register stages from source to peripheral input
   sequence virt_loop_s;
      output_select_register[NPINS*6 +: 6] == `RPS_OC_REFCLK &&
      input_select_register[5:0] == `RPS_VIRT_BASE;
   endsequence
   virt_loop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      virt_loop_s ##1 $stable(input_select_register[5:0]) |=>
      periph_in[0] == $past(reference_clock_out, 2))
      else $error("virtual pin loop broken");

   // Two-way functions hand the pin back to the port when not driving
   spi_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_SCKO |=> $past(spi_clock_oe) ?
      (pad_oe[0] && pad_out[0] == $past(spi_clock_out)) : (pad_oe[0] == $past(port_oe[0])))
      else $error("spi clock enable wrong");

   spi_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      output_select_register[5:0] == `RPS_OC_SSO |=> $past(spi_select_oe) ?
      (pad_oe[0] && pad_out[0] == $past(spi_select_out)) : (pad_oe[0] == $past(port_oe[0])))
      else $error("spi select enable wrong");
endmodule // rps_top

// >>> rps_periph_model.sv
// Peripheral and port-logic model facing the pin crossbar.
// Assumes the bench pulses upd with a fresh random word.
`timescale 1ns/1ns
module rps_periph_model (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         upd,
   input  wire logic [127:0] rnd,
   output logic      [16:0]  src,
   output logic      [29:0]  pad_in,
   output logic      [29:0]  port_data,
   output logic      [29:0]  port_oe
);
   logic [106:0] st_reg;
   logic [106:0] st_next;

   // New levels only on request, so the bench knows when sources move
   always_comb begin
      st_next = st_reg;
      if (upd) begin
         st_next = rnd[106:0];
      end
   end

   // Pads keep their level whatever the direction bits hold
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Sources, pad levels, port latch and enable
   assign {port_oe, port_data, pad_in, src} = st_reg;
endmodule // rps_periph_model

// >>> tb.sv
// Self-checking bench for the remappable pin crossbar.
// Assumes the design files and the peripheral model compile first.
`timescale 1ns/1ns
module tb;
   logic                 sys_clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 lock = 1'b0;
   logic                 upd = 1'b0;
   logic                 in_we = 1'b0;
   logic                 out_we = 1'b0;
   logic [5:0]           idx = 6'h00;
   rps_pkg::rps_sel_type wdata = 6'h00;
   logic [127:0]         rnd = '0;
   logic [16:0]          src;
   logic [29:0]          pad_in, port_data, port_oe, pad_out, pad_oe;
   logic [137:0]         in_rb, in_old;
   logic [203:0]         out_rb, out_old;
   logic [22:0]          periph_in;
   int                   n_errors = 0;
   int                   n_checks = 0;
   logic [5:0]           codes [16] = '{6'h03, 6'h04, 6'h07, 6'h08, 6'h09, 6'h12, 6'h13,
      6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2c, 6'h2d, 6'h00};

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   rps_top #(.NPINS(30)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .remap_write_lock(lock), .in_sel_we(in_we),
      .in_sel_idx(idx[4:0]), .out_sel_we(out_we), .out_sel_idx(idx), .sel_wdata(wdata),
      .input_select_register(in_rb), .output_select_register(out_rb),
      .pad_in(pad_in), .port_data(port_data), .port_oe(port_oe),
      .pad_out(pad_out), .pad_oe(pad_oe),
      .serial_transmit_out(src[0]), .serial_request_send_out(src[1]),
      .spi_data_out(src[2]), .spi_clock_out(src[3]), .spi_clock_oe(src[15]),
      .spi_select_out(src[4]), .spi_select_oe(src[16]), .compare_out_first(src[5]),
      .compare_out_second(src[6]), .pwm_sync_out(src[7]), .reference_clock_out(src[8]),
      .comparator_out(src[12:9]), .pwm_gen_four_high(src[13]),
      .pwm_gen_four_low(src[14]), .periph_in(periph_in));

   rps_periph_model model_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .upd(upd), .rnd(rnd), .src(src),
      .pad_in(pad_in), .port_data(port_data), .port_oe(port_oe));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [203:0] ex, input logic [203:0] got);
      n_checks++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         n_errors++;
      end
   endtask

   // One select write; strobe drops a cycle later
   task automatic wr(input logic iw, input logic ow, input logic [5:0] ix, input logic [5:0] v);
      @(posedge sys_clk);
      in_we <= iw;
      out_we <= ow;
      idx <= ix;
      wdata <= v;
      @(posedge sys_clk);
      in_we <= 1'b0;
      out_we <= 1'b0;
   endtask

   task automatic upd_src();
      @(posedge sys_clk);
      upd <= 1'b1;
      rnd <= {$urandom(), $urandom(), $urandom(), $urandom()};
      @(posedge sys_clk);
      upd <= 1'b0;
   endtask

   // Covers the two-stage path from source to pin or input
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // Pin {oe,data}: function with live enable wins, else the port
   function automatic logic [1:0] exp_out(input logic [5:0] c, input int p);
      logic [1:0] r;
      r = {port_oe[p], port_data[p]};
      for (int k = 0; k < 15; k++) begin
         if (codes[k] == c) begin
            r = {(k == 3) ? src[15] : (k == 4) ? src[16] : 1'b1, src[k]};
            if (!r[1]) begin
               r = {port_oe[p], port_data[p]};
            end
         end
      end
      return r;
   endfunction

   task automatic stop_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Hang guard, far beyond the real run length
   initial begin
      #1000000;
      n_errors++;
      stop_test();
   end

   initial begin
      int p;
      int f;
      int ps;
      logic [5:0] c;
      void'($urandom(93));
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("in_sel_rst", {23{6'h3f}}, in_rb);
      chk("out_sel_rst", '0, out_rb);
      chk("periph_in_rst", '0, periph_in);
      chk("pad_oe_rst", '0, pad_oe);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      // Every output code on pin zero first, then on random pins,
      // with input routing beside it
      for (int i = 0; i < 48; i++) begin
         p = (i < 16) ? 0 : $urandom_range(29);
         f = $urandom_range(22);
         ps = $urandom_range(29);
         c = codes[i % 16];
         wr(1'b0, 1'b1, p[5:0], c);
         wr(1'b1, 1'b0, f[5:0], ps[5:0]);
         upd_src();
         settle();
         chk("out_sel", c, out_rb[6*p +: 6]);
         chk("in_sel", ps, in_rb[6*f +: 6]);
         chk("pad", exp_out(c, p), {pad_oe[p], pad_out[p]});
         chk("periph_in", pad_in[ps], periph_in[f]);
      end
      // Comparators into fault inputs through the virtual pins
      for (int v = 0; v < 4; v++) begin
         wr(1'b0, 1'b1, 6'h1e + v, codes[9+v]);
         wr(1'b1, 1'b0, 6'h0d + v, 6'h20 + v);
         upd_src();
         settle();
         chk("virt_loop", src[9+v], periph_in[13+v]);
      end
      // Reference clock through the first virtual pin into the first input
      wr(1'b0, 1'b1, 6'h1e, 6'h26);
      wr(1'b1, 1'b0, 6'h00, 6'h20);
      repeat (2) begin
         upd_src();
         settle();
         chk("virt_ref", src[8], periph_in[0]);
      end
      // All-ones select reads ground whatever the pads do
      wr(1'b1, 1'b0, 6'h00, 6'h3f);
      repeat (4) begin
         upd_src();
         settle();
         chk("in_ground", 1'b0, periph_in[0]);
      end
      // Writes under lock and to missing indices leave selects alone
      in_old = in_rb;
      out_old = out_rb;
      @(posedge sys_clk);
      lock <= 1'b1;
      wr(1'b1, 1'b1, 6'h01, 6'h05);
      @(posedge sys_clk);
      lock <= 1'b0;
      wr(1'b1, 1'b0, 6'h17, 6'h05);
      wr(1'b0, 1'b1, 6'h22, 6'h03);
      settle();
      chk("lock_in", in_old, in_rb);
      chk("lock_out", out_old, out_rb);
      // Input and output writes in one cycle both land
      wr(1'b1, 1'b1, 6'h05, 6'h07);
      settle();
      chk("both_in", 6'h07, in_rb[35:30]);
      chk("both_out", 6'h07, out_rb[35:30]);
      stop_test();
   end
endmodule // tb
